// file: shared/qdtr_pkg.sv
// constants and types for the quad converter register bank
// Overview of operation
// - trigger bit 4 loads synchronous channels together
// - key 1010 in bits 3:0 resets device
// - broadcast write updates broadcast-enabled channels only
// - broadcast value is msb-aligned straight binary
// - status bit 0 shows reference headroom alarm
// - channel code registers at 0x8 to 0xF
// - fourteen-bit code uses upper bits only; channel writes here keep all 16 bits
// - frames are 24 bits, sampled falling edge
// - trigger at 0x05, resets to zero
package qdtr_pkg;
   localparam int          QDTR_FRAME_BITS = 24;        // bits per write frame
   localparam logic [4:0]  QDTR_LAST_BIT   = 5'h17;     // index of final frame bit
   localparam logic [3:0]  QDTR_ADDR_TRIG  = 4'h5;      // trigger register
   localparam logic [3:0]  QDTR_ADDR_BCAST = 4'h6;      // broadcast register
   localparam logic [3:0]  QDTR_ADDR_STAT  = 4'h7;      // status register
   localparam logic [3:0]  QDTR_ADDR_CH0   = 4'h8;      // first channel register
   localparam logic [3:0]  QDTR_ADDR_CHF   = 4'hF;      // last channel register
   localparam int          QDTR_LOAD_BIT   = 4;         // sync load strobe position
   localparam logic [3:0]  QDTR_RESET_KEY  = 4'hA;      // soft reset key
   localparam logic [15:0] QDTR_ZERO_SCALE = 16'h0000;  // zero scale reset code
   localparam logic [15:0] QDTR_MID_SCALE  = 16'h8000;  // mid scale reset code
   localparam logic [15:0] QDTR_REG_RESET  = 16'h0000;  // trigger/broadcast reset
   localparam logic [15:0] QDTR_MASK_14    = 16'hFFFC;  // fourteen-bit code mask
   localparam int          QDTR_CH_SEL_W   = 3;         // channel index width
   localparam int          QDTR_NUM_CH     = 8;         // channel slots 0x8..0xF
   // decoded write frame
   typedef struct packed {
      logic        rw;    // frame bit 23, 1 = read
      logic [2:0]  rsvd;  // frame bits 22:20
      logic [3:0]  addr;  // register address
      logic [15:0] data;  // register value
   } qdtr_frame_s;
endpackage : qdtr_pkg

// file: hdl/qdtr_regs.sv
// serial write framing and trigger/broadcast/status/channel registers
`timescale 1ns/1ps
`default_nettype none
module qdtr_regs (
   // clock and reset
   input  wire logic                              sys_clk,
   input  wire logic                              rst_n,
   // serial pins from host
   input  wire logic                              cs_n,
   input  wire logic                              sclk,
   input  wire logic                              sdi,
   // device-side straps and analog status
   input  wire logic                              reset_level_select_pin,
   input  wire logic                              headroom_low,
   input  wire logic [qdtr_pkg::QDTR_NUM_CH-1:0]  sync_mode,
   input  wire logic [qdtr_pkg::QDTR_NUM_CH-1:0]  bcast_mode,
   // conversion channel side
   output var  logic [qdtr_pkg::QDTR_NUM_CH*16-1:0] chan_active,
   output var  logic                              sync_load_strobe,
   output var  logic                              reference_headroom_alarm,
   output var  logic                              soft_reset_pulse
);
   import qdtr_pkg::*;

   // synchronisers for pins
   logic [1:0] cs_s_q, sclk_s_q, sdi_s_q, sel_s_q, alm_s_q;
   logic       sclk_prev_q;                      // last synced clock level
   logic [23:0] shift_q;                          // frame shift register
   logic [4:0]  cnt_q;                            // bits captured, saturating
   logic [15:0] chan_q [QDTR_NUM_CH];             // channel code registers
   logic [15:0] bcast_q;                          // broadcast value
   logic        bcast_done_q;                     // broadcast landed last cycle
   logic        done_q;                           // frame complete pulse
   logic        cs_low_prev_q;                    // last synced select level
   // counter parks here so an overlong frame never looks complete
   localparam logic [4:0] CNT_FULL = 5'h1F;

   // two flops per pin; logic reads only the second stage
   always_ff @(posedge sys_clk) begin
      cs_s_q   <= {cs_s_q[0], cs_n};
      sclk_s_q <= {sclk_s_q[0], sclk};
      sdi_s_q  <= {sdi_s_q[0], sdi};
      sel_s_q  <= {sel_s_q[0], reset_level_select_pin};
      alm_s_q  <= {alm_s_q[0], headroom_low};
   end

   // edge and frame decode
   wire         cs_low   = ~cs_s_q[1];
   wire         fall     = sclk_prev_q & ~sclk_s_q[1];
   // select release: high now after a low select last cycle
   wire         cs_rise  = cs_s_q[1] & cs_low_prev_q;
   qdtr_frame_s frm;
   assign frm = qdtr_frame_s'(shift_q);
   wire         wr_ok    = done_q & ~frm.rw;
   wire         wr_trig  = wr_ok & (frm.addr == QDTR_ADDR_TRIG);
   wire         wr_bcast = wr_ok & (frm.addr == QDTR_ADDR_BCAST);
   wire         wr_chan  = wr_ok & (frm.addr >= QDTR_ADDR_CH0);
   wire         key_hit  = wr_trig & (frm.data[3:0] == QDTR_RESET_KEY);
   wire         do_reset = ~rst_n | soft_reset_pulse;
   wire [15:0]  rst_code = sel_s_q[1] ? QDTR_MID_SCALE : QDTR_ZERO_SCALE;
   wire [2:0]   ch_idx   = frm.addr[QDTR_CH_SEL_W-1:0];

   // shift in on falling sclk, msb first
   always_ff @(posedge sys_clk) begin
      sclk_prev_q   <= sclk_s_q[1];
      cs_low_prev_q <= cs_low;
      if (!rst_n || !cs_low) begin
         cnt_q <= 5'h00;
      end else if (fall && cnt_q != CNT_FULL) begin
         // bits past the 24th are counted, not shifted, so the
         // frame is refused at select release
         if (cnt_q <= QDTR_LAST_BIT) begin
            shift_q <= {shift_q[22:0], sdi_s_q[1]};
         end
         cnt_q   <= cnt_q + 5'h01;
      end
   end

   // frame ends when cs rises after exactly 24 bits
   // done is a one-cycle pulse; shift_q holds still until next select
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= cs_rise & (cnt_q == 5'(QDTR_FRAME_BITS));
      end
   end

   // broadcast register; the trigger is write-only and lives only
   // as the two strobes below, which reset low
   always_ff @(posedge sys_clk) begin
      if (do_reset) begin
         bcast_q      <= QDTR_REG_RESET;
         bcast_done_q <= 1'b0;
      end else begin
         if (wr_bcast) begin
            bcast_q <= frm.data;
         end
         bcast_done_q <= wr_bcast;
      end
   end

   // strobes to channels, and the synced headroom alarm level
   // each strobe is one cycle wide, as done_q is
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync_load_strobe         <= 1'b0;
         soft_reset_pulse         <= 1'b0;
         reference_headroom_alarm <= 1'b0;
      end else begin
         sync_load_strobe         <= wr_trig & frm.data[QDTR_LOAD_BIT];
         soft_reset_pulse         <= key_hit;
         reference_headroom_alarm <= alm_s_q[1];
      end
   end

   // channel code registers
   // priority: reset, direct write, broadcast
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < QDTR_NUM_CH; i++) begin
         if (do_reset) begin
            chan_q[i] <= rst_code;
         end else if (wr_chan && ch_idx == 3'(i)) begin
            chan_q[i] <= frm.data;
         end else if (wr_bcast && bcast_mode[i]) begin
            chan_q[i] <= frm.data;
         end
      end
   end

   // active codes; synchronous channels wait for load strobe or a broadcast write with their bcast_mode bit set
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < QDTR_NUM_CH; i++) begin
         if (do_reset) begin
            chan_active[i*16 +: 16] <= rst_code;
         end else if (!sync_mode[i] || sync_load_strobe ||
                      (bcast_done_q && bcast_mode[i])) begin
            // broadcast goes live at once, even on a synchronous channel
            chan_active[i*16 +: 16] <= chan_q[i];
         end
      end
   end

   // status read value: reserved bits zero
   // no read path exists; the value is kept for the check below
   wire [15:0] status_rd = {15'h0000, reference_headroom_alarm};

   // guards on strobes, registers and framing
   // load strobe only after a trigger write with bit 4
   sync_load_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      sync_load_strobe |-> $past(wr_trig) && $past(frm.data[QDTR_LOAD_BIT]))
      else $error("load strobe without trigger");
   soft_key_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_trig && frm.data[3:0] != QDTR_RESET_KEY |=> !soft_reset_pulse)
      else $error("reset without key");
   bcast_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_bcast && !bcast_mode[7] && !wr_chan && !soft_reset_pulse
      |=> chan_q[7] == $past(chan_q[7]))
      else $error("broadcast hit disabled channel");
   bcast_val_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_bcast && !soft_reset_pulse |=> bcast_q == $past(frm.data))
      else $error("broadcast value lost");
   alarm_bit_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(alm_s_q[1]) == reference_headroom_alarm || !$past(rst_n))
      else $error("alarm mismatch");
   chan_write_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_chan && ch_idx == 3'h2 && !soft_reset_pulse |=> chan_q[2] == $past(frm.data))
      else $error("channel write lost");
   reset_code_a : assert property (@(posedge sys_clk)
      soft_reset_pulse && rst_n |=> chan_q[1] == $past(rst_code))
      else $error("bad reset code");
   status_rsvd_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      status_rd[15:1] == 15'h0000)
      else $error("reserved status bits set");
   trig_rsvd_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_trig && !frm.data[QDTR_LOAD_BIT] && frm.data[3:0] != QDTR_RESET_KEY
      |=> !sync_load_strobe && !soft_reset_pulse)
      else $error("reserved trigger bits acted");
   frame_len_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
      done_q |-> $past(cnt_q) == 5'(QDTR_FRAME_BITS))
      else $error("short frame accepted");
endmodule : qdtr_regs
`default_nettype wire

// file: tb/qdtr_host_model.sv
// host serial master model that sends write frames
`timescale 1ns/1ps
`default_nettype none
module qdtr_host_model (
   // serial pins toward the device
   output var logic cs_n,
   output var logic sclk,
   output var logic sdi
);
   initial begin
      cs_n = 1'b1;  // idle: deselected
      sclk = 1'b0;  // link clock stands still
      sdi  = 1'b0;
   end
   // send the top n bits of f; data moves mid-low so the fall finds it settled
   task automatic send(input logic [23:0] f, input int n);
      cs_n = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         #12 sdi = f[i];
         #12 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      #12 sdi = ~sdi;  // released line shows no stale bit
      #12 cs_n = 1'b1;
      #60;
   endtask : send
endmodule : qdtr_host_model
`default_nettype wire

// file: tb/qdtr_regs_tb_top.sv
// self-checking bench for the quad converter register bank
`timescale 1ns/1ps
`default_nettype none
module qdtr_regs_tb_top;
   import qdtr_pkg::*;
   logic         sys_clk = 1'b0;  // 200 MHz clock
   logic         rst_n   = 1'b0;  // reset, active low
   logic         rsel    = 1'b0;  // reset level select
   logic         hlow    = 1'b0;  // headroom low input
   logic [7:0]   smode   = 8'h00; // sync mode per slot
   logic [7:0]   bmode   = 8'h00; // broadcast mode per slot
   wire logic    cs_n, sclk, sdi;
   logic [127:0] chan;            // active codes
   logic         ldst, alarm, srst;
   int           err_total = 0, compares = 0, n_ld = 0, n_sr = 0;
   always #2.5 sys_clk = ~sys_clk;
   qdtr_host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi));
   qdtr_regs DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .reset_level_select_pin(rsel), .headroom_low(hlow), .sync_mode(smode),
      .bcast_mode(bmode), .chan_active(chan), .sync_load_strobe(ldst),
      .reference_headroom_alarm(alarm), .soft_reset_pulse(srst));
   // count strobe cycles; a stretched pulse counts once for each cycle it is high
   always @(posedge sys_clk) begin
      if (ldst === 1'b1) n_ld++;
      if (srst === 1'b1) n_sr++;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task print_verdict;
      if (err_total == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task do_reset(input logic sel);
      rst_n = 1'b0;
      rsel  = sel;
      tick(6);
      rst_n = 1'b1;
      tick(3);
   endtask : do_reset
   // frame of n bits, started and left just after a clock edge
   task xfer(input logic [23:0] f, input int n);
      tick(1);
      host.send(f, n);
      tick(1);
   endtask : xfer
   task wr(input logic [3:0] a, input logic [15:0] d);
      xfer({4'h0, a, d}, 24);
   endtask : wr
   task see(input int s, input logic [15:0] e);
      chk(chan[s*16+:16], e);
   endtask : see
   // hang guard
   initial begin
      #200000;
      err_total++;
      print_verdict;
   end
   initial begin
      do_reset(1'b0);
      for (int i = 0; i < 8; i++) see(i, QDTR_ZERO_SCALE);
      for (int i = 0; i < 8; i++) wr(QDTR_ADDR_CH0 + 4'(i), 16'(i * 16'h1111 + 16'h0123));
      for (int i = 0; i < 8; i++) see(i, 16'(i * 16'h1111 + 16'h0123));
      xfer({4'h0, QDTR_ADDR_CH0, 16'hFFFF}, 23);
      see(0, 16'h0123);
      bmode = 8'h0F;
      wr(QDTR_ADDR_BCAST, 16'hFEDC);
      for (int i = 0; i < 8; i++) see(i, i < 4 ? 16'hFEDC : 16'(i * 16'h1111 + 16'h0123));
      bmode = 8'h00;
      smode = 8'hF0;
      wr(4'hC, 16'h5A5A);
      see(4, 16'h4567);
      wr(QDTR_ADDR_TRIG, 16'h0010);
      see(4, 16'h5A5A);
      chk(16'(n_ld), 16'h0001);
      bmode = 8'h20;
      wr(QDTR_ADDR_BCAST, 16'h1357);
      see(5, 16'h1357);
      see(4, 16'h5A5A);
      bmode = 8'h00;
      wr(QDTR_ADDR_TRIG, 16'hFFE5);
      chk(16'(n_ld + n_sr), 16'h0001);
      hlow = 1'b1;
      tick(8);
      chk({15'h0, alarm}, 16'h0001);
      hlow = 1'b0;
      tick(8);
      chk({15'h0, alarm}, 16'h0000);
      rsel = 1'b1;
      wr(QDTR_ADDR_TRIG, {12'h000, QDTR_RESET_KEY});
      chk(16'(n_sr), 16'h0001);
      see(4, QDTR_MID_SCALE);
      do_reset(1'b1);
      for (int i = 0; i < 8; i++) see(i, QDTR_MID_SCALE);
      print_verdict;
   end
endmodule : qdtr_regs_tb_top
`default_nettype wire
